// *** rtl/lpm_pkg.sv ***
// Shared constants and types for the panel mode configuration registers
package lpm_pkg;
	localparam int          LPM_ADDR_W      = 17;
	localparam int          LPM_DATA_W      = 8;
	localparam int          LPM_PROD_W      = 6;
	localparam int          LPM_REV_W       = 2;
	localparam logic [16:0] LPM_WIN_FIRST   = 17'h1_ffe0;
	localparam logic [16:0] LPM_WIN_LAST    = 17'h1_ffff;
	localparam logic [16:0] LPM_ADDR_ID     = 17'h1_ffe0;
	localparam logic [16:0] LPM_ADDR_MODE   = 17'h1_ffe1;
	localparam logic [7:0]  LPM_MODE_RST    = 8'h00;
	localparam logic [7:0]  LPM_RDATA_RST   = 8'h00;
	localparam logic [7:0]  LPM_UNMAPPED    = 8'h00;
	// Arbitrary identification values, not those of any real part
	localparam logic [5:0]  LPM_PRODUCT_DEF = 6'h2a;
	localparam logic [1:0]  LPM_REVISION_DEF = 2'h1;

	// Data width field codes
	localparam logic [1:0]  LPM_WIDTH_4BIT  = 2'h0;
	localparam logic [1:0]  LPM_WIDTH_8BIT  = 2'h1;
	localparam logic [1:0]  LPM_WIDTH_RSV   = 2'h2;
	localparam logic [1:0]  LPM_WIDTH_8F2   = 2'h3;

	// Mode register layout, bit 7 down to bit 0
	typedef struct packed {
		logic       panel_type_select;
		logic       dual_select;
		logic       colour_select;
		logic       line_polarity;
		logic       frame_polarity;
		logic       shift_clock_mask;
		logic [1:0] data_width;
	} lpm_mode_type;

	typedef struct packed {
		logic                  cs_n;
		logic [LPM_ADDR_W-1:0] host_address_bus;
		logic                  wr_en;
		logic                  rd_en;
		logic [LPM_DATA_W-1:0] wdata;
	} lpm_host_req_type;

	typedef struct packed {
		logic active_matrix_panel;
		logic dual_drive;
		logic colour_drive;
		logic shift_masked_blank;
	} lpm_panel_cfg_type;

	typedef enum logic [3:0] {
		LPM_FMT_MONO_S4  = 4'h0,
		LPM_FMT_MONO_S8  = 4'h1,
		LPM_FMT_MONO_D8  = 4'h2,
		LPM_FMT_COL_S4   = 4'h3,
		LPM_FMT_COL_S8F1 = 4'h4,
		LPM_FMT_COL_S8F2 = 4'h5,
		LPM_FMT_COL_D8   = 4'h6,
		LPM_FMT_AM9      = 4'h7,
		LPM_FMT_AM12     = 4'h8,
		LPM_FMT_RESERVED = 4'hf
	} lpm_fmt_type;
endpackage : lpm_pkg

// *** rtl/lpm_format_decode.sv ***
// Decoder from the mode register to the panel data format
`timescale 1ns/1ns
module lpm_format_decode
	import lpm_pkg::*;
(
	input  lpm_pkg::lpm_mode_type mode_in,
	output lpm_pkg::lpm_fmt_type  fmt_out,
	output logic                  reserved_out
);
	always_comb begin
		fmt_out = LPM_FMT_RESERVED;
		if (mode_in.panel_type_select) begin
			// Drive and colour selections do not matter here
			fmt_out = mode_in.data_width[0] ? LPM_FMT_AM12 : LPM_FMT_AM9;
		end else begin
			case ({mode_in.colour_select, mode_in.dual_select})
				2'h0: begin
					if (mode_in.data_width == LPM_WIDTH_4BIT) begin
						fmt_out = LPM_FMT_MONO_S4;
					end else if (mode_in.data_width == LPM_WIDTH_8BIT) begin
						fmt_out = LPM_FMT_MONO_S8;
					end
				end
				2'h1: begin
					if (mode_in.data_width == LPM_WIDTH_8BIT) begin
						fmt_out = LPM_FMT_MONO_D8;
					end
				end
				2'h2: begin
					case (mode_in.data_width)
						LPM_WIDTH_4BIT: fmt_out = LPM_FMT_COL_S4;
						LPM_WIDTH_8BIT: fmt_out = LPM_FMT_COL_S8F1;
						LPM_WIDTH_8F2:  fmt_out = LPM_FMT_COL_S8F2;
						default:        fmt_out = LPM_FMT_RESERVED;
					endcase
				end
				2'h3: begin
					if (mode_in.data_width == LPM_WIDTH_8BIT) begin
						fmt_out = LPM_FMT_COL_D8;
					end
				end
				default: fmt_out = LPM_FMT_RESERVED;
			endcase
		end
	end

	assign reserved_out = (fmt_out == LPM_FMT_RESERVED);
endmodule : lpm_format_decode

// *** rtl/lpm_mode_regs.sv ***
// Identification and panel mode registers with panel signal conditioning
`timescale 1ns/1ns
// Behaviour
// - Mode register bits clear to zero at reset
// - Identification register read-only, product and revision
// - Mode register read/write at second window byte
// - Top mode bit picks passive or active-matrix
// - Active-matrix ignores drive and colour selections
// - Bit six selects single or dual drive
// - Bit five selects monochrome or colour drive
// - Active-matrix bit four sets line pulse polarity
// - Active-matrix bit three sets frame pulse polarity
// - Mask shift clock when blanking, colour passive/mask
// - Mono single passive: codes 00, 01 valid
// - Mono dual passive: only code 01 valid
// - Colour single passive: codes 00, 01, 11
// - Colour dual passive: only code 01 valid
// - Active-matrix low width bit picks 9/12-bit
// - Access only with chip select in top window
module lpm_mode_regs
	import lpm_pkg::*;
#(
	parameter logic [5:0] PRODUCT_CODE  = LPM_PRODUCT_DEF,
	parameter logic [1:0] REVISION_CODE = LPM_REVISION_DEF
) (
	input  wire logic                       clk_sys_in,
	input  wire logic                       nrst_in,
	input  lpm_pkg::lpm_host_req_type       host_req_in,
	output logic [lpm_pkg::LPM_DATA_W-1:0]  host_rdata_out,
	output logic                            host_rvalid_out,
	input  wire logic                       line_raw_in,
	input  wire logic                       frame_raw_in,
	input  wire logic                       shift_raw_in,
	input  wire logic                       hblank_in,
	input  wire logic                       vblank_in,
	output logic                            panel_line_pulse_out,
	output logic                            panel_frame_pulse_out,
	output logic                            panel_shift_clock_out,
	output lpm_pkg::lpm_panel_cfg_type      panel_cfg_out,
	output lpm_pkg::lpm_fmt_type            panel_fmt_out,
	output logic                            fmt_reserved_out
);
	import lpm_pkg::*;

	lpm_mode_type          mode_reg;
	logic [LPM_DATA_W-1:0] rdata_reg;
	logic [LPM_DATA_W-1:0] rdata_next;
	logic                  rvalid_reg;
	logic                  line_reg;
	logic                  frame_reg;
	logic                  shift_reg;
	lpm_fmt_type           fmt_reg;
	lpm_fmt_type           fmt_next;
	logic                  reserved_reg;
	logic                  reserved_next;
	logic                  in_window;
	logic                  acc_ok;
	logic                  wr_mode;
	logic                  rd_any;
	logic                  active_mode;
	logic                  colour_eff;
	logic                  dual_eff;
	logic                  mask_blank;
	logic                  blanking;
	logic                  line_next;
	logic                  frame_next;
	logic                  shift_next;
	logic                  id_sel;
	logic                  mode_sel;

	// Address decode over the register window
	assign in_window = (host_req_in.host_address_bus >= LPM_WIN_FIRST) &&
		(host_req_in.host_address_bus <= LPM_WIN_LAST);
	assign acc_ok   = !host_req_in.cs_n && in_window;
	assign id_sel   = (host_req_in.host_address_bus == LPM_ADDR_ID);
	assign mode_sel = (host_req_in.host_address_bus == LPM_ADDR_MODE);
	assign wr_mode  = acc_ok && host_req_in.wr_en && mode_sel;
	assign rd_any   = acc_ok && host_req_in.rd_en;

	// Mode register; the identification byte takes no write
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mode_reg <= LPM_MODE_RST;
		end else if (wr_mode) begin
			mode_reg <= host_req_in.wdata;
		end
	end

	// Read data mux; other window bytes read as zero
	always_comb begin
		rdata_next = LPM_UNMAPPED;
		if (id_sel) begin
			rdata_next = {PRODUCT_CODE, REVISION_CODE};
		end else if (mode_sel) begin
			rdata_next = mode_reg;
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_reg  <= LPM_RDATA_RST;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= rd_any;
			if (rd_any) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	assign host_rdata_out  = rdata_reg;
	assign host_rvalid_out = rvalid_reg;

	// Effective panel selections
	assign active_mode = mode_reg.panel_type_select;
	assign dual_eff    = mode_reg.dual_select && !active_mode;
	assign colour_eff  = mode_reg.colour_select && !active_mode;
	assign mask_blank  = colour_eff || mode_reg.shift_clock_mask;
	assign blanking    = hblank_in || vblank_in;

	// One driver for the whole struct
	assign panel_cfg_out = '{
		active_matrix_panel: active_mode,
		dual_drive:          dual_eff,
		colour_drive:        colour_eff,
		shift_masked_blank:  mask_blank
	};

	// Polarity applies only to active-matrix panels; raw pulses are active high
	always_comb begin
		line_next  = line_raw_in;
		frame_next = frame_raw_in;
		if (active_mode) begin
			line_next  = mode_reg.line_polarity ? line_raw_in : !line_raw_in;
			frame_next = mode_reg.frame_polarity ? frame_raw_in : !frame_raw_in;
		end
		shift_next = shift_raw_in && !(mask_blank && blanking);
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			line_reg  <= 1'b0;
			frame_reg <= 1'b0;
			shift_reg <= 1'b0;
		end else begin
			line_reg  <= line_next;
			frame_reg <= frame_next;
			shift_reg <= shift_next;
		end
	end

	assign panel_line_pulse_out  = line_reg;
	assign panel_frame_pulse_out = frame_reg;
	assign panel_shift_clock_out = shift_reg;

	lpm_format_decode u_format_decode (
		.mode_in      (mode_reg),
		.fmt_out      (fmt_next),
		.reserved_out (reserved_next)
	);

	// Registered format; reserved codes are flagged, not corrected
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fmt_reg      <= LPM_FMT_MONO_S4;
			reserved_reg <= 1'b0;
		end else begin
			fmt_reg      <= fmt_next;
			reserved_reg <= reserved_next;
		end
	end

	assign panel_fmt_out    = fmt_reg;
	assign fmt_reserved_out = reserved_reg;

	sequence seq_id_read;
		acc_ok && host_req_in.rd_en && id_sel;
	endsequence

	sequence seq_mode_read;
		acc_ok && host_req_in.rd_en && mode_sel;
	endsequence

	sequence seq_mode_write;
		acc_ok && host_req_in.wr_en && mode_sel;
	endsequence

	sequence seq_outside_access;
		(host_req_in.cs_n || !in_window) && host_req_in.rd_en;
	endsequence

	AST_RESET_CLEAR: assert property (
		@(posedge clk_sys_in)
		!$past(nrst_in) && nrst_in |-> mode_reg == LPM_MODE_RST && !rvalid_reg
	) else $error("Mode register not clear after reset");

	AST_ID_READ: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		seq_id_read |=> host_rvalid_out &&
			host_rdata_out == {PRODUCT_CODE, REVISION_CODE}
	) else $error("Identification read returned wrong value");

	AST_ID_NO_WRITE: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		acc_ok && host_req_in.wr_en && id_sel |=> $stable(mode_reg)
	) else $error("Write to identification byte changed mode register");

	AST_MODE_WRITE_READ: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		seq_mode_write ##1 (seq_mode_read and !host_req_in.wr_en) |=>
			host_rdata_out == $past(mode_reg) && host_rvalid_out
	) else $error("Mode register readback mismatch");

	AST_MODE_WRITE: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		seq_mode_write |=> mode_reg == $past(host_req_in.wdata)
	) else $error("Mode register did not take written byte");

	AST_TYPE_SELECT: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		panel_cfg_out.active_matrix_panel == mode_reg.panel_type_select
	) else $error("Panel type does not follow bit seven");

	AST_AM_IGNORES: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		mode_reg.panel_type_select |->
			!panel_cfg_out.dual_drive && !panel_cfg_out.colour_drive ##1
			(panel_fmt_out == LPM_FMT_AM9 || panel_fmt_out == LPM_FMT_AM12)
	) else $error("Active-matrix mode used drive or colour selection");

	AST_DRIVE_COLOUR: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		!mode_reg.panel_type_select |->
			panel_cfg_out.dual_drive == mode_reg.dual_select &&
			panel_cfg_out.colour_drive == mode_reg.colour_select
	) else $error("Passive drive or colour selection not applied");

	AST_LINE_POL: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		nrst_in |=> panel_line_pulse_out == ($past(mode_reg.panel_type_select) &&
			!$past(mode_reg.line_polarity) ? !$past(line_raw_in) : $past(line_raw_in))
	) else $error("Line pulse polarity wrong");

	AST_FRAME_POL: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		mode_reg.panel_type_select && !mode_reg.frame_polarity && frame_raw_in
		|=> !panel_frame_pulse_out
	) else $error("Active-low frame pulse not driven low");

	AST_SHIFT_MASK: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(mode_reg.shift_clock_mask ||
			(mode_reg.colour_select && !mode_reg.panel_type_select)) &&
		(hblank_in || vblank_in) |=> !panel_shift_clock_out
	) else $error("Shift clock not masked during blanking");

	AST_SHIFT_PASS: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		nrst_in && !hblank_in && !vblank_in |=>
			panel_shift_clock_out == $past(shift_raw_in)
	) else $error("Shift clock blocked during display period");

	AST_MONO_SINGLE: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		mode_reg[7:5] == 3'h0 && mode_reg.data_width == LPM_WIDTH_8BIT
		|=> panel_fmt_out == LPM_FMT_MONO_S8 && !fmt_reserved_out
	) else $error("Mono single 8-bit format not decoded");

	AST_MONO_DUAL_RSV: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		mode_reg[7:5] == 3'h2 && mode_reg.data_width == LPM_WIDTH_4BIT
		|=> fmt_reserved_out
	) else $error("Mono dual reserved code not flagged");

	AST_COL_SINGLE_F2: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		mode_reg[7:5] == 3'h1 && mode_reg.data_width == LPM_WIDTH_8F2
		|=> panel_fmt_out == LPM_FMT_COL_S8F2
	) else $error("Colour single format 2 not decoded");

	AST_COL_DUAL: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		mode_reg[7:5] == 3'h3 |=>
			fmt_reserved_out == ($past(mode_reg.data_width) != LPM_WIDTH_8BIT)
	) else $error("Colour dual format decode wrong");

	AST_AM_WIDTH: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		mode_reg.panel_type_select && mode_reg.data_width[0]
		|=> panel_fmt_out == LPM_FMT_AM12
	) else $error("Active-matrix 12-bit width not decoded");

	AST_WINDOW: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		seq_outside_access |=> !host_rvalid_out
	) else $error("Answer given outside chip select window");

	AST_NO_STRAY_WRITE: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		!wr_mode |=> $stable(mode_reg)
	) else $error("Mode register changed without a valid write");

	AST_FRAME_POL_HIGH: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		mode_reg.panel_type_select && mode_reg.frame_polarity && frame_raw_in
		|=> panel_frame_pulse_out
	) else $error("Active-high frame pulse not driven high");

	AST_FRAME_PASSIVE: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		nrst_in && !mode_reg.panel_type_select |=>
			panel_frame_pulse_out == $past(frame_raw_in)
	) else $error("Passive frame pulse not passed through");

	AST_SHIFT_UNMASKED: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		nrst_in && !mode_reg.shift_clock_mask &&
			!(mode_reg.colour_select && !mode_reg.panel_type_select)
		|=> panel_shift_clock_out == $past(shift_raw_in)
	) else $error("Shift clock masked without a mask condition");

	AST_MONO_SINGLE_4: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		mode_reg[7:5] == 3'h0 && mode_reg.data_width == LPM_WIDTH_4BIT
		|=> panel_fmt_out == LPM_FMT_MONO_S4 && !fmt_reserved_out
	) else $error("Mono single 4-bit format not decoded");

	AST_MONO_DUAL_8: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		mode_reg[7:5] == 3'h2 && mode_reg.data_width == LPM_WIDTH_8BIT
		|=> panel_fmt_out == LPM_FMT_MONO_D8 && !fmt_reserved_out
	) else $error("Mono dual 8-bit format not decoded");

	AST_COL_SINGLE_4: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		mode_reg[7:5] == 3'h1 && mode_reg.data_width == LPM_WIDTH_4BIT
		|=> panel_fmt_out == LPM_FMT_COL_S4 && !fmt_reserved_out
	) else $error("Colour single 4-bit format not decoded");

	AST_COL_SINGLE_F1: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		mode_reg[7:5] == 3'h1 && mode_reg.data_width == LPM_WIDTH_8BIT
		|=> panel_fmt_out == LPM_FMT_COL_S8F1 && !fmt_reserved_out
	) else $error("Colour single format 1 not decoded");

	AST_AM_9: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		mode_reg.panel_type_select && !mode_reg.data_width[0]
		|=> panel_fmt_out == LPM_FMT_AM9 && !fmt_reserved_out
	) else $error("Active-matrix 9-bit width not decoded");

	AST_MODE_READ: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		seq_mode_read |=> host_rvalid_out && host_rdata_out == $past(mode_reg)
	) else $error("Mode register read returned wrong value");

	AST_UNMAPPED_READ: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		acc_ok && host_req_in.rd_en && !id_sel && !mode_sel
		|=> host_rvalid_out && host_rdata_out == LPM_UNMAPPED
	) else $error("Unmapped window byte did not read as zero");
endmodule : lpm_mode_regs

// *** test/lpm_host_model.sv ***
// Host processor model driving the register window
`timescale 1ns/1ns
module lpm_host_model
	import lpm_pkg::*;
(
	input  wire logic                  clk_sys_in,
	output lpm_pkg::lpm_host_req_type  host_req_out,
	input  wire logic [7:0]            rdata_in,
	input  wire logic                  rvalid_in
);
	import lpm_pkg::*;
	initial host_req_out = '{1'b1, 17'h0_0000, 1'b0, 1'b0, 8'h00};
	// One byte transfer; lines not held are turned over so stale values never match
	task automatic xfer(input logic cs_n, input logic [16:0] addr, input logic wr,
		input logic rd, input logic [7:0] wd, output logic [7:0] d, output logic ok);
		@(posedge clk_sys_in);
		host_req_out <= '{cs_n, addr, wr, rd, wd};
		@(posedge clk_sys_in);
		host_req_out <= '{1'b1, ~addr, 1'b0, 1'b0, ~wd};
		#1;
		ok = rvalid_in;
		d = rdata_in;
	endtask : xfer
	// Write then read the same byte on the next cycle, returning the read answer
	task automatic wr_then_rd(input logic [16:0] addr, input logic [7:0] wd,
		output logic [7:0] d, output logic ok);
		@(posedge clk_sys_in);
		host_req_out <= '{1'b0, addr, 1'b1, 1'b0, wd};
		@(posedge clk_sys_in);
		host_req_out <= '{1'b0, addr, 1'b0, 1'b1, ~wd};
		@(posedge clk_sys_in);
		host_req_out <= '{1'b1, ~addr, 1'b0, 1'b0, ~wd};
		#1;
		ok = rvalid_in;
		d = rdata_in;
	endtask : wr_then_rd
endmodule : lpm_host_model

// *** test/tb_lpm_mode_regs.sv ***
// Self-checking testbench for the panel mode configuration registers
`timescale 1ns/1ns
module tb_lpm_mode_regs;
	import lpm_pkg::*;
	logic              clk_sys_in = 1'b0;
	logic              nrst_in = 1'b0;
	lpm_host_req_type  host_req;
	logic [7:0]        rdata;
	logic              rvalid;
	logic              line_raw = 1'b0;
	logic              frame_raw = 1'b0;
	logic              shift_raw = 1'b0;
	logic              hblank = 1'b0;
	logic              vblank = 1'b0;
	logic              line_out;
	logic              frame_out;
	logic              shift_out;
	logic              fmt_rsv;
	lpm_panel_cfg_type cfg;
	lpm_fmt_type       fmt;
	int                n_errors = 0;
	int                total_checks = 0;
	logic [7:0]        modes [10] = '{8'h00, 8'h01, 8'h41, 8'h20, 8'h21, 8'h23, 8'h61,
		8'he0, 8'hf9, 8'h05};
	lpm_fmt_type       fmts [10] = '{LPM_FMT_MONO_S4, LPM_FMT_MONO_S8, LPM_FMT_MONO_D8,
		LPM_FMT_COL_S4, LPM_FMT_COL_S8F1, LPM_FMT_COL_S8F2, LPM_FMT_COL_D8, LPM_FMT_AM9,
		LPM_FMT_AM12, LPM_FMT_MONO_S8};
	logic [3:0]        cfgs [10] = '{4'h0, 4'h0, 4'h4, 4'h3, 4'h3, 4'h3, 4'h7, 4'h8, 4'h8,
		4'h1};

	always #20 clk_sys_in = ~clk_sys_in;

	lpm_mode_regs uut (
		.clk_sys_in            (clk_sys_in),
		.nrst_in               (nrst_in),
		.host_req_in           (host_req),
		.host_rdata_out        (rdata),
		.host_rvalid_out       (rvalid),
		.line_raw_in           (line_raw),
		.frame_raw_in          (frame_raw),
		.shift_raw_in          (shift_raw),
		.hblank_in             (hblank),
		.vblank_in             (vblank),
		.panel_line_pulse_out  (line_out),
		.panel_frame_pulse_out (frame_out),
		.panel_shift_clock_out (shift_out),
		.panel_cfg_out         (cfg),
		.panel_fmt_out         (fmt),
		.fmt_reserved_out      (fmt_rsv)
	);

	lpm_host_model host (
		.clk_sys_in   (clk_sys_in),
		.host_req_out (host_req),
		.rdata_in     (rdata),
		.rvalid_in    (rvalid)
	);

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic test_id_window();
		logic [7:0] d;
		logic       ok;
		check({4'h0, cfg}, 8'h00, "cfg after reset");
		check({4'h0, fmt}, {4'h0, LPM_FMT_MONO_S4}, "fmt after reset");
		host.xfer(1'b0, LPM_ADDR_MODE, 1'b0, 1'b1, 8'h00, d, ok);
		check(d, LPM_MODE_RST, "mode after reset");
		host.xfer(1'b0, LPM_ADDR_ID, 1'b1, 1'b0, 8'hff, d, ok);
		host.xfer(1'b0, LPM_ADDR_ID, 1'b0, 1'b1, 8'h00, d, ok);
		check(d, {LPM_PRODUCT_DEF, LPM_REVISION_DEF}, "id read");
		check({7'h0, ok}, 8'h01, "id valid");
		host.xfer(1'b1, LPM_ADDR_MODE, 1'b1, 1'b0, 8'h80, d, ok);
		host.xfer(1'b0, 17'h1_ffdf, 1'b1, 1'b0, 8'h80, d, ok);
		host.xfer(1'b0, 17'h1_ffdf, 1'b0, 1'b1, 8'h00, d, ok);
		check({7'h0, ok}, 8'h00, "outside window answered");
		host.xfer(1'b1, LPM_ADDR_MODE, 1'b0, 1'b1, 8'h00, d, ok);
		check({7'h0, ok}, 8'h00, "deselected read answered");
		host.xfer(1'b0, LPM_ADDR_MODE, 1'b0, 1'b1, 8'h00, d, ok);
		check(d, 8'h00, "refused writes landed");
		host.xfer(1'b0, 17'h1_ffe5, 1'b0, 1'b1, 8'h00, d, ok);
		check(d, LPM_UNMAPPED, "unmapped byte");
		check({7'h0, ok}, 8'h01, "unmapped byte valid");
		$display("test_id_window done");
	endtask : test_id_window

	task automatic test_modes();
		logic [7:0] d;
		logic       ok;
		logic [7:0] m;
		logic       am;
		for (int k = 0; k < 10; k++) begin
			m = modes[k];
			am = m[7];
			host.xfer(1'b0, LPM_ADDR_MODE, 1'b1, 1'b0, m, d, ok);
			host.xfer(1'b0, LPM_ADDR_MODE, 1'b0, 1'b1, 8'h00, d, ok);
			check(d, m, "mode readback");
			check({7'h0, ok}, 8'h01, "mode read valid");
			check({4'h0, cfg}, {4'h0, cfgs[k]}, "panel cfg");
			check({4'h0, fmt}, {4'h0, fmts[k]}, "panel fmt");
			check({7'h0, fmt_rsv}, 8'h00, "valid fmt flagged");
			for (int i = 0; i < 8; i++) begin
				@(posedge clk_sys_in);
				line_raw <= i[0];
				frame_raw <= ~i[0];
				shift_raw <= 1'b1;
				hblank <= i[1];
				vblank <= i[2];
				@(posedge clk_sys_in);
				#1;
				check({7'h0, line_out}, {7'h0, i[0] ^ (am & ~m[4])}, "line");
				check({7'h0, frame_out}, {7'h0, ~i[0] ^ (am & ~m[3])}, "frame");
				check({7'h0, shift_out},
					{7'h0, ~((i[1] | i[2]) & ((m[5] & ~am) | m[2]))}, "shift");
			end
		end
		$display("test_modes done");
	endtask : test_modes

	task automatic test_mid_reset();
		logic [7:0] d;
		logic       ok;
		host.wr_then_rd(LPM_ADDR_MODE, 8'hf9, d, ok);
		check(d, 8'hf9, "read right after write");
		check({7'h0, ok}, 8'h01, "read after write valid");
		@(posedge clk_sys_in);
		nrst_in <= 1'b0;
		@(posedge clk_sys_in);
		#1;
		check({4'h0, cfg}, 8'h00, "cfg in reset");
		@(posedge clk_sys_in);
		nrst_in <= 1'b1;
		host.xfer(1'b0, LPM_ADDR_MODE, 1'b0, 1'b1, 8'h00, d, ok);
		check(d, 8'h00, "mode after second reset");
		$display("test_mid_reset done");
	endtask : test_mid_reset

	task automatic results();
		$display("Comparisons %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results

	initial begin
		repeat (8) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		test_id_window();
		test_modes();
		test_mid_reset();
		results();
	end

	initial begin
		#(40 * 5000);
		n_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		results();
	end
endmodule : tb_lpm_mode_regs
